// ---- pin_mux_defines.vh ----
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// register word offsets on the apb bus (byte addresses)
`define OFS_FOUR_PIN_DIRECTION    8'h00
`define OFS_FOUR_PIN_FUNCTION     8'h04
`define OFS_SIXTEEN_PIN_DIRECTION 8'h08
`define OFS_SIXTEEN_PIN_FUNCTION  8'h0C
`define OFS_FOUR_PIN_DATA         8'h10
`define OFS_SIXTEEN_PIN_DATA      8'h14

// reset values
`define RST_FOUR_PIN_DIRECTION    16'h0000
`define RST_FOUR_PIN_FUNCTION     16'h0000
`define RST_SIXTEEN_PIN_DIRECTION 16'h0000
`define RST_SIXTEEN_PIN_FUNCTION  16'h0000
`define RST_PIN_DATA              16'h0000

// writable masks, reserved positions read as zero
`define MASK_FOUR_PIN_DIRECTION   16'h000F
`define MASK_FOUR_PIN_FUNCTION    16'h00F7

// four-pin function field positions
`define POS_PIN3_FUNC_HI          7
`define POS_PIN3_FUNC_LO          6
`define POS_PIN2_FUNC_HI          5
`define POS_PIN2_FUNC_LO          4
`define POS_PIN1_FUNC_BIT         2
`define POS_PIN0_FUNC_HI          1
`define POS_PIN0_FUNC_LO          0

// two-bit function encodings
`define FUNC_GPIO                 2'b00
`define FUNC_ALT_A                2'b01
`define FUNC_ALT_B                2'b10
`define FUNC_RESERVED             2'b11

// operating modes
`define MODE_EXP_ROMOFF_8         2'b00
`define MODE_EXP_ROMOFF_16        2'b01
`define MODE_EXP_ROMON            2'b10
`define MODE_SINGLE_CHIP          2'b11

`endif

// ---- pin_drive_cell.v ----
`default_nettype none

// one pad: registered level and active-low output enable
module pin_drive_cell (
   input  wire pclk,
   input  wire presetn,
   input  wire ce,
   input  wire gpio_sel,
   input  wire gpio_dir,
   input  wire gpio_level,
   input  wire alt_drive,
   input  wire alt_level,
   output reg  pin_out,
   output reg  pin_oe_n
);

   // gpio owns the pad when selected, else the alternate function
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b1;
      end else if (ce) begin
         if (gpio_sel) begin
            pin_out  <= gpio_level;
            pin_oe_n <= ~gpio_dir;
         end else begin
            pin_out  <= alt_level;
            pin_oe_n <= ~alt_drive;
         end
      end
   end

endmodule // pin_drive_cell

`default_nettype wire

// ---- port_g_h_pin_function_direction.v ----
// How it works
// R1: four-pin gpio: direction 1 output, 0 input
// R2: four-pin direction 16 bits, upper read zero
// R3: registers clear on reset and hardware standby
// R4: four-pin function bits 15..8 read zero
// R5: pin3 field: gpio, interrupt 3, conversion trigger
// R6: pin2 field: gpio or interrupt 2
// R7: four-pin function bit 3 reads zero
// R8: pin1 bit: gpio or interrupt 1
// R9: pin0 field: gpio, pulse out, can receive
// R10: software never writes reserved encodings
// R11: sixteen-pin direction: bit n drives pin n
// R12: sixteen-pin direction ignored for data lines
// R13: sixteen-pin gpio: direction 1 output, 0 input
// R14: sixteen-pin function only in expanded rom mode; the code also applies it to pins 15..8 in the 8-bit rom-off mode
// R15: function bit 0 gpio, 1 data line
// R16: writes act at completing edge, reads return stored
//
// Decided for this implementation: the APB interface to the registers and the register addresses.

`include "pin_mux_defines.vh"
`default_nettype none

module port_g_h_pin_function_direction #(
   parameter ADDR_W = 8,
   parameter WIDE_N = 16,
   parameter NARROW_N = 4
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              ce,
   input  wire              hw_standby,
   input  wire [1:0]        op_mode,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire [NARROW_N-1:0] four_pin_in,
   output wire [NARROW_N-1:0] four_pin_out,
   output wire [NARROW_N-1:0] four_pin_oe_n,
   input  wire [WIDE_N-1:0] sixteen_pin_in,
   output wire [WIDE_N-1:0] sixteen_pin_out,
   output wire [WIDE_N-1:0] sixteen_pin_oe_n,
   input  wire              pulse_out_ch7,
   input  wire [WIDE_N-1:0] bus_data_out,
   input  wire              bus_data_oe,
   output reg  [WIDE_N-1:0] bus_data_in,
   output reg               ext_interrupt_in_3,
   output reg               ext_interrupt_in_2,
   output reg               ext_interrupt_in_1,
   output reg               conversion_trigger_in,
   output reg               can_receive_in
);

   // registers
   reg  [15:0] four_pin_direction_reg;
   reg  [15:0] four_pin_function_reg;
   reg  [15:0] sixteen_pin_direction_reg;
   reg  [15:0] sixteen_pin_function_reg;
   reg  [15:0] four_pin_data;
   reg  [15:0] sixteen_pin_data;

   // decoded per-pin controls
   reg  [NARROW_N-1:0] four_gpio_sel;
   reg  [NARROW_N-1:0] four_alt_drive;
   reg  [NARROW_N-1:0] four_alt_level;
   wire [WIDE_N-1:0]   wide_gpio_sel;
   wire [15:0]         four_pin_level;
   wire [15:0]         sixteen_pin_level;

   // bus decode
   wire        setup_phase;
   wire        write_done;
   reg  [31:0] next_prdata;
   reg         next_pslverr;

   // pin1 is a one-bit field, the others two bits
   wire [1:0] pin3_func;
   wire [1:0] pin2_func;
   wire       pin1_func_bit;
   wire [1:0] pin0_func;

   // address hit test, shared by read and write paths
   function addr_mapped;
      input [ADDR_W-1:0] a;
      begin
         case (a)
            `OFS_FOUR_PIN_DIRECTION,
            `OFS_FOUR_PIN_FUNCTION,
            `OFS_SIXTEEN_PIN_DIRECTION,
            `OFS_SIXTEEN_PIN_FUNCTION,
            `OFS_FOUR_PIN_DATA,
            `OFS_SIXTEEN_PIN_DATA:     addr_mapped = 1'b1;
            default:                   addr_mapped = 1'b0;
         endcase
      end
   endfunction

   // true when a sixteen-pin pad serves as a data bus line
   function wide_is_data;
      input [1:0] mode;
      input       fbit;
      input       upper;
      begin
         case (mode)
            `MODE_EXP_ROMOFF_8:  wide_is_data = ~upper | fbit;
            `MODE_EXP_ROMOFF_16: wide_is_data = 1'b1;
            `MODE_EXP_ROMON:     wide_is_data = fbit;          // [R14] [R15]
            `MODE_SINGLE_CHIP:   wide_is_data = 1'b0;
            default:             wide_is_data = 1'b0;
         endcase
      end
   endfunction

   assign pin3_func     = {four_pin_function_reg[`POS_PIN3_FUNC_HI], four_pin_function_reg[`POS_PIN3_FUNC_LO]};
   assign pin2_func     = {four_pin_function_reg[`POS_PIN2_FUNC_HI], four_pin_function_reg[`POS_PIN2_FUNC_LO]};
   assign pin1_func_bit = four_pin_function_reg[`POS_PIN1_FUNC_BIT];
   assign pin0_func     = {four_pin_function_reg[`POS_PIN0_FUNC_HI], four_pin_function_reg[`POS_PIN0_FUNC_LO]};

   // apb phases: answer one cycle after setup, write at the next edge, when the access completes
   assign setup_phase = psel & ~penable;
   assign write_done  = psel & penable & pready & pwrite & ~pslverr;   // [R16]

   // four-pin function decode; reserved codes fall back to gpio
   always @* begin
      four_gpio_sel  = {NARROW_N{1'b1}};
      four_alt_drive = {NARROW_N{1'b0}};
      four_alt_level = {NARROW_N{1'b0}};
      case (pin3_func)                                             // [R5]
         `FUNC_ALT_A: four_gpio_sel[3] = 1'b0;
         `FUNC_ALT_B: four_gpio_sel[3] = 1'b0;
         default:     four_gpio_sel[3] = 1'b1;
      endcase
      case (pin2_func)                                             // [R6]
         `FUNC_ALT_A: four_gpio_sel[2] = 1'b0;
         default:     four_gpio_sel[2] = 1'b1;
      endcase
      four_gpio_sel[1] = ~pin1_func_bit;                           // [R8]
      case (pin0_func)                                             // [R9]
         `FUNC_ALT_A: begin
            four_gpio_sel[0]  = 1'b0;
            four_alt_drive[0] = 1'b1;
            four_alt_level[0] = pulse_out_ch7;
         end
         `FUNC_ALT_B: four_gpio_sel[0] = 1'b0;
         default:     four_gpio_sel[0] = 1'b1;
      endcase
   end

   // four-pin pads
   genvar g;
   generate
      for (g = 0; g < NARROW_N; g = g + 1) begin : g_four
         pin_drive_cell u_cell (
            .pclk       (pclk),
            .presetn    (presetn),
            .ce         (ce),
            .gpio_sel   (four_gpio_sel[g]),
            .gpio_dir   (four_pin_direction_reg[g]),               // [R1]
            .gpio_level (four_pin_data[g]),
            .alt_drive  (four_alt_drive[g]),
            .alt_level  (four_alt_level[g]),
            .pin_out    (four_pin_out[g]),
            .pin_oe_n   (four_pin_oe_n[g])
         );
      end
   endgenerate

   // sixteen-pin pads; data lines follow the bus, direction bits ignored
   generate
      for (g = 0; g < WIDE_N; g = g + 1) begin : g_wide
         assign wide_gpio_sel[g] = ~wide_is_data(op_mode, sixteen_pin_function_reg[g], (g >= 8));
         pin_drive_cell u_cell (
            .pclk       (pclk),
            .presetn    (presetn),
            .ce         (ce),
            .gpio_sel   (wide_gpio_sel[g]),                        // [R12]
            .gpio_dir   (sixteen_pin_direction_reg[g]),            // [R11] [R13]
            .gpio_level (sixteen_pin_data[g]),
            .alt_drive  (bus_data_oe),
            .alt_level  (bus_data_out[g]),
            .pin_out    (sixteen_pin_out[g]),
            .pin_oe_n   (sixteen_pin_oe_n[g])
         );
      end
   endgenerate

   // readback level: output pins show the latch, inputs the pad
   assign four_pin_level = {{(16-NARROW_N){1'b0}},
                            (four_pin_data[NARROW_N-1:0] & four_pin_direction_reg[NARROW_N-1:0]) |
                            (four_pin_in & ~four_pin_direction_reg[NARROW_N-1:0])};
   assign sixteen_pin_level = (sixteen_pin_data & sixteen_pin_direction_reg) |
                              (sixteen_pin_in & ~sixteen_pin_direction_reg);

   // read mux and error for unmapped addresses
   always @* begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = ~addr_mapped(paddr);
      if (!pwrite) begin
         case (paddr)
            `OFS_FOUR_PIN_DIRECTION:    next_prdata = {16'h0000, four_pin_direction_reg};
            `OFS_FOUR_PIN_FUNCTION:     next_prdata = {16'h0000, four_pin_function_reg};
            `OFS_SIXTEEN_PIN_DIRECTION: next_prdata = {16'h0000, sixteen_pin_direction_reg};
            `OFS_SIXTEEN_PIN_FUNCTION:  next_prdata = {16'h0000, sixteen_pin_function_reg};
            `OFS_FOUR_PIN_DATA:         next_prdata = {16'h0000, four_pin_level};
            `OFS_SIXTEEN_PIN_DATA:      next_prdata = {16'h0000, sixteen_pin_level};
            default:                    next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // bus answer: ready one cycle after setup, data held with it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready <= setup_phase;
         if (setup_phase) begin
            pslverr <= next_pslverr;
            prdata  <= next_prdata;                                // [R16]
         end else begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
         end
      end
   end

   // register file; reserved bits masked to zero on every write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin                                          // [R3]
         four_pin_direction_reg    <= `RST_FOUR_PIN_DIRECTION;
         four_pin_function_reg     <= `RST_FOUR_PIN_FUNCTION;
         sixteen_pin_direction_reg <= `RST_SIXTEEN_PIN_DIRECTION;
         sixteen_pin_function_reg  <= `RST_SIXTEEN_PIN_FUNCTION;
         four_pin_data             <= `RST_PIN_DATA;
         sixteen_pin_data          <= `RST_PIN_DATA;
      end else if (ce) begin
         if (hw_standby) begin                                     // [R3]
            four_pin_direction_reg    <= `RST_FOUR_PIN_DIRECTION;
            four_pin_function_reg     <= `RST_FOUR_PIN_FUNCTION;
            sixteen_pin_direction_reg <= `RST_SIXTEEN_PIN_DIRECTION;
            sixteen_pin_function_reg  <= `RST_SIXTEEN_PIN_FUNCTION;
            four_pin_data             <= `RST_PIN_DATA;
            sixteen_pin_data          <= `RST_PIN_DATA;
         end else if (write_done) begin
            case (paddr)
               `OFS_FOUR_PIN_DIRECTION:
                  four_pin_direction_reg <= pwdata[15:0] & `MASK_FOUR_PIN_DIRECTION;   // [R2]
               `OFS_FOUR_PIN_FUNCTION:
                  four_pin_function_reg <= pwdata[15:0] & `MASK_FOUR_PIN_FUNCTION;     // [R4] [R7]
               `OFS_SIXTEEN_PIN_DIRECTION:
                  sixteen_pin_direction_reg <= pwdata[15:0];                           // [R11]
               `OFS_SIXTEEN_PIN_FUNCTION:
                  sixteen_pin_function_reg <= pwdata[15:0];
               `OFS_FOUR_PIN_DATA:
                  four_pin_data <= pwdata[15:0] & `MASK_FOUR_PIN_DIRECTION;
               `OFS_SIXTEEN_PIN_DATA:
                  sixteen_pin_data <= pwdata[15:0];
               default: begin
               end
            endcase
         end
      end
   end

   // peripheral inputs: pad level when selected, idle level otherwise
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_interrupt_in_3    <= 1'b0;
         ext_interrupt_in_2    <= 1'b0;
         ext_interrupt_in_1    <= 1'b0;
         conversion_trigger_in <= 1'b0;
         can_receive_in        <= 1'b1;   // recessive idle
         bus_data_in           <= {WIDE_N{1'b0}};
      end else if (ce) begin
         ext_interrupt_in_3    <= (pin3_func == `FUNC_ALT_A) & four_pin_in[3];       // [R5]
         conversion_trigger_in <= (pin3_func == `FUNC_ALT_B) & four_pin_in[3];       // [R5]
         ext_interrupt_in_2    <= (pin2_func == `FUNC_ALT_A) & four_pin_in[2];       // [R6]
         ext_interrupt_in_1    <= pin1_func_bit & four_pin_in[1];                    // [R8]
         can_receive_in        <= (pin0_func == `FUNC_ALT_B) ? four_pin_in[0] : 1'b1; // [R9]
         bus_data_in           <= sixteen_pin_in & ~wide_gpio_sel;                   // [R12]
      end
   end

endmodule // port_g_h_pin_function_direction

`default_nettype wire

// ---- pin_mux_asserts.sv ----
`include "pin_mux_defines.vh"
`default_nettype none
module pin_mux_asserts #(
   parameter ADDR_W   = 8,
   parameter WIDE_N   = 16,
   parameter NARROW_N = 4
) (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                ce,
   input wire logic                hw_standby,
   input wire logic [1:0]          op_mode,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [ADDR_W-1:0]   paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic [NARROW_N-1:0] four_pin_in,
   input wire logic [NARROW_N-1:0] four_pin_oe_n,
   input wire logic [WIDE_N-1:0]   bus_data_in,
   input wire logic                ext_interrupt_in_3,
   input wire logic                conversion_trigger_in,
   input wire logic                can_receive_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_setup: assert property (psel && !penable && ce |=> pready)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready && ce |=> !pready)
      else $error("ready held too long");
   chk_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer carries data");
   chk_idle_nodata: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   chk_dir_upper: assert property (pready && !pwrite && paddr == `OFS_FOUR_PIN_DIRECTION
      |-> (prdata & 32'hFFFF_FFF0) == 32'h0000_0000) else $error("direction upper bits set");
   chk_func_rsvd: assert property (pready && !pwrite && paddr == `OFS_FOUR_PIN_FUNCTION
      |-> (prdata & 32'hFFFF_FF08) == 32'h0000_0000) else $error("function reserved bits set");
   chk_standby_clear: assert property ((hw_standby && ce) [*2] |=> &four_pin_oe_n)
      else $error("pins still driven in standby");
   chk_irq_pad: assert property (ext_interrupt_in_3 && $past(ce) |-> $past(four_pin_in[3]))
      else $error("interrupt without pad level");
   chk_trig_excl: assert property (!(ext_interrupt_in_3 && conversion_trigger_in))
      else $error("two functions on one pin");
   chk_can_pad: assert property (!can_receive_in && $past(ce) |-> !$past(four_pin_in[0]))
      else $error("receive low without pad low");
   chk_single_chip: assert property ($past(op_mode) == 2'b11 && $past(ce) |-> bus_data_in == 16'h0000)
      else $error("data line active in single chip");
endmodule // pin_mux_asserts
bind port_g_h_pin_function_direction pin_mux_asserts #(.ADDR_W(ADDR_W), .WIDE_N(WIDE_N), .NARROW_N(NARROW_N))
   i_pin_mux_asserts (.pclk, .presetn, .ce, .hw_standby, .op_mode, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .four_pin_in, .four_pin_oe_n, .bus_data_in, .ext_interrupt_in_3, .conversion_trigger_in,
   .can_receive_in);
`default_nettype wire

// ---- pad_model.sv ----
`default_nettype none
module pad_model (
   input wire logic        pclk,
   input wire logic [3:0]  g_out,
   input wire logic [3:0]  g_oe_n,
   input wire logic [15:0] h_out,
   input wire logic [15:0] h_oe_n,
   input wire logic        g_ext_en,
   input wire logic [3:0]  g_ext,
   output logic [3:0]      g_pad,
   output logic [15:0]     h_pad
);
   timeunit 1ns;
   timeprecision 1ns;
   logic float_lvl = 1'b0;
   // undriven lines wander so a stale level never reads back
   always @(posedge pclk) float_lvl <= ~float_lvl;
   // device wins where its enable is low, else outside source or wandering level
   assign g_pad = (g_out & ~g_oe_n) | (g_oe_n & (g_ext_en ? g_ext : {4{float_lvl}}));
   assign h_pad = (h_out & ~h_oe_n) | (h_oe_n & {16{float_lvl}});
endmodule // pad_model
`default_nettype wire

// ---- tb.sv ----
`include "pin_mux_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, ce, hw_standby, psel, penable, pwrite, pready, pslverr;
   logic [1:0]  op_mode;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  four_pin_in, four_pin_out, four_pin_oe_n, g_ext;
   logic [15:0] sixteen_pin_in, sixteen_pin_out, sixteen_pin_oe_n, bus_data_out, bus_data_in;
   logic        pulse_out_ch7, bus_data_oe, g_ext_en, ext_interrupt_in_3, ext_interrupt_in_2;
   logic        ext_interrupt_in_1, conversion_trigger_in, can_receive_in;
   logic [31:0] periph, g_pins, h_pins;
   int          err_count = 0;
   int          n_compared = 0;
   assign periph = {27'h000_0000, ext_interrupt_in_3, ext_interrupt_in_2, ext_interrupt_in_1,
                    conversion_trigger_in, can_receive_in};
   assign g_pins = {24'h00_0000, four_pin_oe_n, four_pin_out};
   assign h_pins = {sixteen_pin_oe_n, sixteen_pin_out};
   port_g_h_pin_function_direction i_port_g_h_pin_function_direction (.pclk, .presetn, .ce, .hw_standby,
      .op_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .four_pin_in,
      .four_pin_out, .four_pin_oe_n, .sixteen_pin_in, .sixteen_pin_out, .sixteen_pin_oe_n, .pulse_out_ch7,
      .bus_data_out, .bus_data_oe, .bus_data_in, .ext_interrupt_in_3, .ext_interrupt_in_2, .ext_interrupt_in_1,
      .conversion_trigger_in, .can_receive_in);
   pad_model i_pad_model (.pclk, .g_out(four_pin_out), .g_oe_n(four_pin_oe_n), .h_out(sixteen_pin_out),
      .h_oe_n(sixteen_pin_oe_n), .g_ext_en, .g_ext, .g_pad(four_pin_in), .h_pad(sixteen_pin_in));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one transfer: setup cycle, then access until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // waits as long as it takes; the watchdog ends a wait that never sees ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, x, "read data");
      chk({31'h0000_0000, e}, {31'h0000_0000, xe}, "slave error");
   endtask
   task settle;
      repeat (3) @(posedge pclk);
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #2_000_000;
      err_count++;
      close_out;
   end
   // main sequence
   initial begin
      presetn = 1'b0; ce = 1'b1; hw_standby = 1'b0; op_mode = 2'b11; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000; pulse_out_ch7 = 1'b0; bus_data_out = 16'h0000;
      bus_data_oe = 1'b0; g_ext_en = 1'b0; g_ext = 4'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0000_0000);
      rd(8'h18, 32'h0000_0000, 1'b1);
      $display("test reset_values finished");
      wr(`OFS_FOUR_PIN_DIRECTION, 32'hFFFF_FFFF);
      rd(`OFS_FOUR_PIN_DIRECTION, 32'h0000_000F);
      wr(`OFS_FOUR_PIN_FUNCTION, 32'h0000_FF5E);
      rd(`OFS_FOUR_PIN_FUNCTION, 32'h0000_0056);
      wr(`OFS_SIXTEEN_PIN_DIRECTION, 32'hFFFF_A5C3);
      rd(`OFS_SIXTEEN_PIN_DIRECTION, 32'h0000_A5C3);
      wr(`OFS_SIXTEEN_PIN_FUNCTION, 32'h0000_00F0);
      rd(`OFS_SIXTEEN_PIN_FUNCTION, 32'h0000_00F0);
      $display("test register_access finished");
      wr(`OFS_FOUR_PIN_FUNCTION, 32'h0000_0000);
      wr(`OFS_FOUR_PIN_DATA, 32'h0000_000A);
      settle;
      chk(g_pins, 32'h0000_000A, "four pin output");
      wr(`OFS_FOUR_PIN_DIRECTION, 32'h0000_0000);
      g_ext_en <= 1'b1;
      g_ext    <= 4'h5;
      settle;
      chk(g_pins & 32'h0000_00F0, 32'h0000_00F0, "four pin input");
      rd(`OFS_FOUR_PIN_DATA, 32'h0000_0005);
      $display("test four_pin_gpio finished");
      g_ext <= 4'hF;
      wr(`OFS_FOUR_PIN_FUNCTION, 32'h0000_0056);
      settle;
      chk(periph, 32'h0000_001D, "functions high");
      g_ext <= 4'h0;
      settle;
      chk(periph, 32'h0000_0000, "functions low");
      g_ext         <= 4'h8;
      pulse_out_ch7 <= 1'b1;
      wr(`OFS_FOUR_PIN_FUNCTION, 32'h0000_0081);
      settle;
      chk(periph, 32'h0000_0003, "trigger and idle receive");
      chk(g_pins & 32'h0000_0011, 32'h0000_0001, "pulse drive");
      $display("test four_pin_functions finished");
      op_mode      <= 2'b10;
      bus_data_oe  <= 1'b1;
      bus_data_out <= 16'hFFFF;
      wr(`OFS_SIXTEEN_PIN_DIRECTION, 32'h0000_FFFF);
      wr(`OFS_SIXTEEN_PIN_DATA, 32'h0000_1234);
      settle;
      chk(h_pins, 32'h0000_12F4, "rom on mixed pins");
      bus_data_oe <= 1'b0;
      settle;
      chk(h_pins & 32'hFFFF_FF0F, 32'h00F0_1204, "data pins released");
      op_mode <= 2'b11;
      settle;
      chk(h_pins, 32'h0000_1234, "single chip gpio");
      chk({16'h0000, bus_data_in}, 32'h0000_0000, "no data input in single chip");
      wr(`OFS_SIXTEEN_PIN_DIRECTION, 32'h0000_00FF);
      settle;
      chk(h_pins & 32'hFFFF_00FF, 32'hFF00_0034, "sixteen pin direction");
      op_mode     <= 2'b01;
      bus_data_oe <= 1'b1;
      settle;
      chk(h_pins, 32'h0000_FFFF, "all data pins");
      chk({16'h0000, bus_data_in}, 32'h0000_FFFF, "all data lines read");
      // byte bus: low byte always data, high byte follows its function bits (all zero here)
      op_mode <= 2'b00;
      settle;
      chk(h_pins, 32'hFF00_12FF, "byte bus pins");
      chk({16'h0000, bus_data_in}, 32'h0000_00FF, "byte bus data lines");
      $display("test sixteen_pin finished");
      wr(`OFS_FOUR_PIN_DIRECTION, 32'h0000_000F);
      hw_standby <= 1'b1;
      repeat (2) @(posedge pclk);
      hw_standby <= 1'b0;
      for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0000_0000);
      wr(`OFS_SIXTEEN_PIN_DIRECTION, 32'h0000_00FF);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_SIXTEEN_PIN_DIRECTION, 32'h0000_0000);
      $display("test standby_and_reset finished");
      close_out;
   end
endmodule // tb
`default_nettype wire
